// ---- hdl/ncr_pkg.sv ----
// Package: register numbers, field layouts, reset values, tokens, message types and states for the node bank
package ncr_pkg;

   // Register numbers carried in configuration messages
   localparam logic [7:0] NCR_REG_DEVICE_ID = 8'h00;
   localparam logic [7:0] NCR_REG_SWITCH_DESC = 8'h01;
   localparam logic [7:0] NCR_REG_SWITCH_CFG = 8'h04;
   localparam logic [7:0] NCR_REG_NODE_ID = 8'h05;
   localparam logic [7:0] NCR_REG_PLL = 8'h06;
   localparam logic [7:0] NCR_REG_CLK_DIV = 8'h07;
   localparam logic [7:0] NCR_REG_REF_CLK = 8'h08;
   localparam logic [7:0] NCR_REG_JTAG_ID = 8'h09;
   localparam logic [7:0] NCR_REG_USER_CODE = 8'h0A;
   localparam logic [7:0] NCR_REG_DIR_LO = 8'h0C;
   localparam logic [7:0] NCR_REG_DIR_HI = 8'h0D;
   localparam logic [7:0] NCR_REG_DBG_T0 = 8'h10;
   localparam logic [7:0] NCR_REG_DBG_T1 = 8'h11;
   localparam logic [7:0] NCR_REG_DBG_SRC = 8'h1F;

   // Switch configuration field positions
   localparam int NCR_CFG_WLOCK_BIT = 31;
   localparam int NCR_CFG_PLL_LOCK_BIT = 8;
   localparam int NCR_CFG_HDR_BIT = 0;

   // Identification field positions
   localparam int NCR_ID_BOOT_LSB = 16;
   localparam int NCR_ID_REV_LSB = 8;
   localparam int NCR_ID_VER_LSB = 0;
   localparam int NCR_DESC_LINKS_LSB = 16;
   localparam int NCR_DESC_SWPROC_LSB = 8;
   localparam int NCR_DESC_DEVPROC_LSB = 0;
   localparam int NCR_NODE_ID_W = 16;

   // Reset values
   localparam logic [31:0] NCR_CFG_RST = 32'h0000_0000;
   localparam logic [15:0] NCR_NODE_ID_RST = 16'h0000;
   localparam logic [31:0] NCR_RW_RST = 32'h0000_0000;

   // Response control tokens
   localparam logic [7:0] NCR_TOK_ACK = 8'h03;
   localparam logic [7:0] NCR_TOK_NACK = 8'h04;
   localparam logic [7:0] NCR_TOK_END = 8'h01;

   // Configuration request as delivered by the switch network
   typedef struct packed {
      logic write;
      logic [7:0] regnum;
      logic [31:0] wdata;
   } ncr_req_t;

   // Answer to one request
   typedef struct packed {
      logic ok;
      logic [31:0] rdata;
   } ncr_rsp_t;

   // Response sequencer states
   typedef enum logic [1:0] {
      NCR_ST_IDLE = 2'b00,
      NCR_ST_HEAD = 2'b01,
      NCR_ST_DATA = 2'b10,
      NCR_ST_TAIL = 2'b11
   } ncr_state_t;

endpackage

// ---- hdl/ncr_resp_seq.sv ----
// Response sequencer: turns one answer into control and data tokens
`timescale 1ns/1ps
`default_nettype none
module ncr_resp_seq
   import ncr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Answer from the bank
   input wire logic rsp_valid,
   input wire ncr_rsp_t rsp,
   input wire logic rsp_is_read,
   output logic rsp_ready,
   // Token stream toward the requester
   output logic tok_valid,
   output logic tok_ctrl,
   output logic [31:0] tok_data,
   input wire logic tok_ready
);

   ncr_state_t state_r;
   logic ok_r;
   logic read_r;

   // Sequencer only takes an answer while idle
   assign rsp_ready = (state_r == NCR_ST_IDLE);
   assign tok_valid = (state_r != NCR_ST_IDLE);

   // Token walk: head, optional data word, end token
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= NCR_ST_IDLE;
         ok_r <= 1'b0;
         read_r <= 1'b0;
         tok_ctrl <= 1'b0;
         tok_data <= 32'h0000_0000;
      end else begin
         case (state_r)
            NCR_ST_IDLE: begin
               if (rsp_valid) begin
                  ok_r <= rsp.ok;
                  read_r <= rsp_is_read;
                  tok_ctrl <= 1'b1;
                  tok_data <= {24'h00_0000, rsp.ok ? NCR_TOK_ACK : NCR_TOK_NACK};
                  state_r <= NCR_ST_HEAD;
               end
            end
            NCR_ST_HEAD: begin
               if (tok_ready) begin
                  if (ok_r && read_r) begin
                     tok_ctrl <= 1'b0;
                     tok_data <= rsp.rdata;
                     state_r <= NCR_ST_DATA;
                  end else begin
                     tok_ctrl <= 1'b1;
                     tok_data <= {24'h00_0000, NCR_TOK_END};
                     state_r <= NCR_ST_TAIL;
                  end
               end
            end
            NCR_ST_DATA: begin
               if (tok_ready) begin
                  tok_ctrl <= 1'b1;
                  tok_data <= {24'h00_0000, NCR_TOK_END};
                  state_r <= NCR_ST_TAIL;
               end
            end
            NCR_ST_TAIL: begin
               if (tok_ready) begin
                  tok_ctrl <= 1'b0;
                  tok_data <= 32'h0000_0000;
                  state_r <= NCR_ST_IDLE;
               end
            end
            default: state_r <= NCR_ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- hdl/ncr_node_bank.sv ----
// Node configuration register bank behind configuration read and write messages
// Notes on behaviour
// - Config bit 8 set refuses writes to the PLL register; resets clear.
// - Config bit 0 picks header size: 0 two-byte, 1 one-byte; resets zero.
// - Node identifier: writable 16 low bits reset zero, upper half reads zero.
// - Boot pins captured on the first edge after reset release, shown read-only in ID bits 23:16.
// - ID bits 15:8 revision, 7:0 version, read-only; top byte reserved.
// - Description holds link count, switch processors and device processors, read-only.
// - Any accepted PLL write updates settings and pulses a tile reset.
// - Requests carry a register number; the bank decodes it, serves mapped numbers and refuses the rest.
// - Read answer: token 3, data, token 1; failure: token 4, token 1.
`timescale 1ns/1ps
`default_nettype none
module ncr_node_bank
   import ncr_pkg::*;
#(
   parameter logic [7:0] SWITCH_REVISION = 8'h01, // Arbitrary value
   parameter logic [7:0] SWITCH_VERSION = 8'h01, // Arbitrary value
   parameter logic [7:0] NUM_LINKS = 8'h08,
   parameter logic [7:0] NUM_SWITCH_PROCS = 8'h02,
   parameter logic [7:0] NUM_DEVICE_PROCS = 8'h02,
   parameter logic [31:0] JTAG_ID_VALUE = 32'h0000_0001, // Arbitrary value
   parameter logic [31:0] USER_CODE_VALUE = 32'h0000_0000
) (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic reset,
   // Boot control pins, level at reset release is kept
   input wire logic [7:0] boot_control_pins,
   // Configuration requests from the switch network
   input wire logic req_valid,
   input wire ncr_req_t req,
   output logic req_ready,
   // Response tokens
   output logic tok_valid,
   output logic tok_ctrl,
   output logic [31:0] tok_data,
   input wire logic tok_ready,
   // Debug source state shown read-only
   input wire logic [31:0] debug_source_in,
   // Configuration outputs
   output logic one_byte_headers,
   output logic [15:0] node_id,
   output logic [31:0] pll_settings,
   output logic [31:0] switch_clock_divider,
   output logic [31:0] reference_clock,
   output logic [31:0] directions_low,
   output logic [31:0] directions_high,
   output logic [31:0] debug_pin_config_tile0,
   output logic [31:0] debug_pin_config_tile1,
   output logic tile_reset
);

   logic [31:0] cfg_r;
   logic [NCR_NODE_ID_W-1:0] node_id_r;
   logic [7:0] boot_r;
   logic boot_taken_r;
   logic [31:0] pll_r, div_r, ref_r, dirl_r, dirh_r, dbg0_r, dbg1_r;
   logic tile_rst_r;
   logic rsp_ready;
   logic take;
   logic wr_en;
   logic hit;
   logic wr_ok;
   logic [31:0] rd_val;
   ncr_rsp_t rsp_nxt;
   ncr_rsp_t rsp_r;
   logic rsp_valid_r;
   logic rsp_read_r;

   // One request in flight; held until the sequencer drains
   assign req_ready = !rsp_valid_r && rsp_ready;
   assign take = req_valid && req_ready;

   // Decode register number and its read value
   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (req.regnum)
         NCR_REG_DEVICE_ID: rd_val = {8'h00, boot_r, SWITCH_REVISION, SWITCH_VERSION};
         NCR_REG_SWITCH_DESC: rd_val = {8'h00, NUM_LINKS, NUM_SWITCH_PROCS,
            NUM_DEVICE_PROCS};
         NCR_REG_SWITCH_CFG: rd_val = cfg_r;
         NCR_REG_NODE_ID: rd_val = {16'h0000, node_id_r};
         NCR_REG_PLL: rd_val = pll_r;
         NCR_REG_CLK_DIV: rd_val = div_r;
         NCR_REG_REF_CLK: rd_val = ref_r;
         NCR_REG_JTAG_ID: rd_val = JTAG_ID_VALUE;
         NCR_REG_USER_CODE: rd_val = USER_CODE_VALUE;
         NCR_REG_DIR_LO: rd_val = dirl_r;
         NCR_REG_DIR_HI: rd_val = dirh_r;
         NCR_REG_DBG_T0: rd_val = dbg0_r;
         NCR_REG_DBG_T1: rd_val = dbg1_r;
         NCR_REG_DBG_SRC: rd_val = debug_source_in;
         default: hit = 1'b0;
      endcase
   end

   // Write permission: lock bit shuts the whole bank, PLL lock only the PLL
   always_comb begin
      wr_ok = hit && !cfg_r[NCR_CFG_WLOCK_BIT];
      if (req.regnum == NCR_REG_PLL && cfg_r[NCR_CFG_PLL_LOCK_BIT]) begin
         wr_ok = 1'b0;
      end
      case (req.regnum)
         NCR_REG_DEVICE_ID, NCR_REG_SWITCH_DESC, NCR_REG_JTAG_ID,
         NCR_REG_USER_CODE, NCR_REG_DBG_SRC: wr_ok = 1'b0;
         default: ;
      endcase
   end

   assign wr_en = take && req.write && wr_ok;

   // Answer: reads succeed on a mapped number, writes when accepted
   always_comb begin
      rsp_nxt.ok = req.write ? wr_ok : hit;
      rsp_nxt.rdata = rd_val;
   end

   // Hold the answer until the sequencer takes it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
         rsp_read_r <= 1'b0;
      end else if (take) begin
         rsp_valid_r <= 1'b1;
         rsp_r <= rsp_nxt;
         rsp_read_r <= !req.write;
      end else if (rsp_ready) begin
         rsp_valid_r <= 1'b0;
      end
   end

   // Switch configuration: only the three defined bits are stored
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_r <= NCR_CFG_RST;
      end else if (wr_en && req.regnum == NCR_REG_SWITCH_CFG) begin
         cfg_r <= 32'h0000_0000;
         cfg_r[NCR_CFG_WLOCK_BIT] <= req.wdata[NCR_CFG_WLOCK_BIT];
         cfg_r[NCR_CFG_PLL_LOCK_BIT] <= req.wdata[NCR_CFG_PLL_LOCK_BIT];
         cfg_r[NCR_CFG_HDR_BIT] <= req.wdata[NCR_CFG_HDR_BIT];
      end
   end

   // Node identifier keeps its low half only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         node_id_r <= NCR_NODE_ID_RST;
      end else if (wr_en && req.regnum == NCR_REG_NODE_ID) begin
         node_id_r <= req.wdata[NCR_NODE_ID_W-1:0];
      end
   end

   // Boot pins caught on the first edge after reset release
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         boot_r <= 8'h00;
         boot_taken_r <= 1'b0;
      end else if (!boot_taken_r) begin
         boot_r <= boot_control_pins;
         boot_taken_r <= 1'b1;
      end
   end

   // Full-word registers whose fields are interpreted elsewhere
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pll_r <= NCR_RW_RST;
         div_r <= NCR_RW_RST;
         ref_r <= NCR_RW_RST;
         dirl_r <= NCR_RW_RST;
         dirh_r <= NCR_RW_RST;
         dbg0_r <= NCR_RW_RST;
         dbg1_r <= NCR_RW_RST;
      end else if (wr_en) begin
         case (req.regnum)
            NCR_REG_PLL: pll_r <= req.wdata;
            NCR_REG_CLK_DIV: div_r <= req.wdata;
            NCR_REG_REF_CLK: ref_r <= req.wdata;
            NCR_REG_DIR_LO: dirl_r <= req.wdata;
            NCR_REG_DIR_HI: dirh_r <= req.wdata;
            NCR_REG_DBG_T0: dbg0_r <= req.wdata;
            NCR_REG_DBG_T1: dbg1_r <= req.wdata;
            default: ;
         endcase
      end
   end

   // Tile reset pulse, one cycle after an accepted PLL write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tile_rst_r <= 1'b0;
      end else begin
         tile_rst_r <= wr_en && req.regnum == NCR_REG_PLL;
      end
   end

   // Outputs straight from flops
   assign one_byte_headers = cfg_r[NCR_CFG_HDR_BIT];
   assign node_id = node_id_r;
   assign pll_settings = pll_r;
   assign switch_clock_divider = div_r;
   assign reference_clock = ref_r;
   assign directions_low = dirl_r;
   assign directions_high = dirh_r;
   assign debug_pin_config_tile0 = dbg0_r;
   assign debug_pin_config_tile1 = dbg1_r;
   assign tile_reset = tile_rst_r;

   // Token sequencer for the answers
   ncr_resp_seq u_seq (
      .clk(clk),
      .reset(reset),
      .rsp_valid(rsp_valid_r),
      .rsp(rsp_r),
      .rsp_is_read(rsp_read_r),
      .rsp_ready(rsp_ready),
      .tok_valid(tok_valid),
      .tok_ctrl(tok_ctrl),
      .tok_data(tok_data),
      .tok_ready(tok_ready)
   );

endmodule
`default_nettype wire

// ---- dv/ncr_node_bank_chk.sv ----
// Port checker for the node bank
`timescale 1ns/1ps
`default_nettype none
module ncr_node_bank_chk
   import ncr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Requests and tokens
   input wire logic req_valid,
   input wire ncr_req_t req,
   input wire logic req_ready,
   input wire logic tok_valid,
   input wire logic tok_ctrl,
   input wire logic [31:0] tok_data,
   input wire logic tok_ready,
   // Settings
   input wire logic one_byte_headers,
   input wire logic [15:0] node_id,
   input wire logic [31:0] pll_settings,
   input wire logic tile_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Write taken at this edge
   logic wt;
   assign wt = req_valid && req_ready && req.write;
   chk_tile_cause: assert property (tile_reset |-> $past(wt && req.regnum == NCR_REG_PLL))
      else $error("tile reset without PLL write");
   chk_tile_pulse: assert property (tile_reset |=> !tile_reset)
      else $error("tile reset too long");
   chk_pll_reset: assert property ($changed(pll_settings) |-> tile_reset)
      else $error("PLL change without tile reset");
   chk_node_cause: assert property ($changed(node_id) |->
      $past(wt && req.regnum == NCR_REG_NODE_ID) && node_id == $past(req.wdata[15:0]))
      else $error("node id change unexplained");
   chk_hdr_cause: assert property ($changed(one_byte_headers) |->
      $past(wt && req.regnum == NCR_REG_SWITCH_CFG) && one_byte_headers == $past(req.wdata[0]))
      else $error("header mode change unexplained");
   chk_answer_time: assert property (req_valid && req_ready |-> ##2 (tok_valid && tok_ctrl))
      else $error("answer late");
   chk_token_hold: assert property (tok_valid && !tok_ready |=>
      tok_valid && $stable(tok_data) && $stable(tok_ctrl))
      else $error("token dropped");
   chk_fail_tail: assert property (tok_valid && tok_ready && tok_ctrl && tok_data[7:0] == NCR_TOK_NACK
      |-> ##[1:2] (tok_valid && tok_ctrl && tok_data[7:0] == NCR_TOK_END))
      else $error("refusal without end token");
   chk_busy_block: assert property (tok_valid |-> !req_ready)
      else $error("ready while answering");
   cover property (tile_reset);
   cover property (tok_valid && tok_ctrl && tok_data[7:0] == NCR_TOK_NACK);
   cover property (tok_valid && !tok_ready);
endmodule
bind ncr_node_bank ncr_node_bank_chk ncr_node_bank_chk_inst(.clk(clk), .reset(reset),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .tok_valid(tok_valid),
   .tok_ctrl(tok_ctrl), .tok_data(tok_data), .tok_ready(tok_ready),
   .one_byte_headers(one_byte_headers), .node_id(node_id), .pll_settings(pll_settings),
   .tile_reset(tile_reset));
`default_nettype wire

// ---- dv/ncr_req_src.sv ----
// Requester model: one configuration message at a time
`timescale 1ns/1ps
`default_nettype none
module ncr_req_src
   import ncr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Request side
   output logic req_valid,
   output ncr_req_t req,
   input wire logic req_ready,
   // Token side
   input wire logic tok_valid,
   input wire logic tok_ctrl,
   input wire logic [31:0] tok_data,
   output logic tok_ready
);
   logic [32:0] got [0:3];
   int got_n;
   // Idle state at time zero
   initial begin
      req_valid = 1'b0;
      req = '0;
      tok_ready = 1'b0;
   end
   // Stall gives idle cycles before each token is taken
   task automatic xfer(input logic wr, input logic [7:0] num, input logic [31:0] wd,
      input int stall);
      int n;
      logic done;
      got_n = 0;
      done = 1'b0;
      n = 0;
      @(negedge clk);
      req_valid = 1'b1;
      req = '{write: wr, regnum: num, wdata: wd};
      #1;
      while (!req_ready && n < 20) begin
         @(negedge clk);
         #1;
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      // Released lines show a changed pattern, not the old value
      req = ~req;
      for (n = 0; n < 40 && !done; n++) begin
         tok_ready = (n % (stall + 1)) == stall;
         #1;
         if (tok_valid && tok_ready && got_n < 4) begin
            got[got_n] = {tok_ctrl, tok_data};
            got_n++;
            done = tok_ctrl && tok_data[7:0] == NCR_TOK_END;
         end
         @(negedge clk);
      end
      tok_ready = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- dv/ncr_node_bank_test.sv ----
// Testbench for the node configuration bank
`timescale 1ns/1ps
`default_nettype none
module ncr_node_bank_test
   import ncr_pkg::*;
;
   logic clk, reset, req_valid, req_ready, tok_valid, tok_ctrl, tok_ready, hdr1, tile_rst;
   ncr_req_t req;
   logic [31:0] tok_data, pll;
   logic [15:0] node_id;
   logic [7:0] boot_pins;
   logic [31:0] dbg_src, clk_div, ref_clk, dir_lo, dir_hi, dbg_t0, dbg_t1;
   int bad_count, check_count, cycles, tr_seen;
   // Identity values are arbitrary; every output is watched
   ncr_node_bank #(.SWITCH_REVISION(8'h3C), .SWITCH_VERSION(8'h5E), .NUM_LINKS(8'h04),
      .NUM_SWITCH_PROCS(8'h02), .NUM_DEVICE_PROCS(8'h03), .JTAG_ID_VALUE(32'h1357_9BDF),
      .USER_CODE_VALUE(32'h2468_ACE0)) ncr_node_bank_inst(.clk(clk),
      .reset(reset), .boot_control_pins(boot_pins), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .tok_valid(tok_valid), .tok_ctrl(tok_ctrl), .tok_data(tok_data),
      .tok_ready(tok_ready), .debug_source_in(dbg_src), .one_byte_headers(hdr1),
      .node_id(node_id), .pll_settings(pll), .switch_clock_divider(clk_div),
      .reference_clock(ref_clk), .directions_low(dir_lo), .directions_high(dir_hi),
      .debug_pin_config_tile0(dbg_t0), .debug_pin_config_tile1(dbg_t1), .tile_reset(tile_rst));
   ncr_req_src ncr_req_src_inst(.clk(clk), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .tok_valid(tok_valid), .tok_ctrl(tok_ctrl),
      .tok_data(tok_data), .tok_ready(tok_ready));
   // Clock and timeout
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      cycles++;
      tr_seen += (tile_rst === 1'b1);
      if (cycles == 3000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask
   // One message, then its tokens judged
   task automatic txn(input logic wr, input logic [7:0] num, input logic [31:0] wd,
      input logic ok, input logic [31:0] rd, input int stall);
      ncr_req_src_inst.xfer(wr, num, wd, stall);
      check(ncr_req_src_inst.got_n === ((ok && !wr) ? 3 : 2), "token count");
      check(ncr_req_src_inst.got[0][32] === 1'b1 && ncr_req_src_inst.got[0][7:0]
         === (ok ? NCR_TOK_ACK : NCR_TOK_NACK), "head token");
      if (ok && !wr) check(ncr_req_src_inst.got[1] === {1'b0, rd}, "read data");
      check(ncr_req_src_inst.got[ncr_req_src_inst.got_n - 1][7:0] === NCR_TOK_END, "tail");
   endtask
   task automatic t_reset_vals();
      txn(1'b0, NCR_REG_DEVICE_ID, '0, 1'b1, 32'h00A5_3C5E, 0);
      txn(1'b0, NCR_REG_SWITCH_DESC, '0, 1'b1, 32'h0004_0203, 2);
      txn(1'b0, NCR_REG_SWITCH_CFG, '0, 1'b1, 32'h0, 0);
      txn(1'b0, NCR_REG_NODE_ID, '0, 1'b1, 32'h0, 1);
   endtask
   task automatic t_node_id();
      txn(1'b1, NCR_REG_NODE_ID, 32'hFFFF_ABCD, 1'b1, '0, 0);
      txn(1'b0, NCR_REG_NODE_ID, '0, 1'b1, 32'h0000_ABCD, 2);
      check(node_id === 16'hABCD, "node id out");
   endtask
   task automatic t_refusals();
      txn(1'b1, NCR_REG_DEVICE_ID, 32'hFFFF_FFFF, 1'b0, '0, 0);
      txn(1'b0, 8'h02, '0, 1'b0, '0, 1);
      txn(1'b0, NCR_REG_DBG_SRC, '0, 1'b1, 32'h1234_5678, 0);
   endtask
   task automatic t_pll();
      txn(1'b1, NCR_REG_PLL, 32'hCAFE_0001, 1'b1, '0, 0);
      check(pll === 32'hCAFE_0001 && tr_seen === 1, "PLL write");
      txn(1'b1, NCR_REG_SWITCH_CFG, 32'h7FFF_FFFF, 1'b1, '0, 0);
      txn(1'b0, NCR_REG_SWITCH_CFG, '0, 1'b1, 32'h0000_0101, 0);
      check(hdr1 === 1'b1, "one-byte headers");
      txn(1'b1, NCR_REG_PLL, 32'h0, 1'b0, '0, 1);
      check(pll === 32'hCAFE_0001 && tr_seen === 1, "PLL locked");
      txn(1'b0, NCR_REG_PLL, '0, 1'b1, 32'hCAFE_0001, 0);
   endtask
   task automatic t_lock();
      txn(1'b1, NCR_REG_SWITCH_CFG, 32'h8000_0000, 1'b1, '0, 0);
      txn(1'b1, NCR_REG_NODE_ID, 32'h1, 1'b0, '0, 0);
      txn(1'b1, NCR_REG_SWITCH_CFG, 32'h0, 1'b0, '0, 0);
      txn(1'b0, NCR_REG_SWITCH_CFG, '0, 1'b1, 32'h8000_0000, 0);
      check(node_id === 16'hABCD && hdr1 === 1'b0, "locked outputs");
   endtask
   // Second reset in mid-run: lock cleared, boot pins caught only at release
   task automatic t_again();
      @(negedge clk);
      reset = 1'b1;
      boot_pins = 8'h5A;
      repeat (2) @(negedge clk);
      check(node_id === 16'h0 && pll === 32'h0 && hdr1 === 1'b0, "state in reset");
      check(tile_rst === 1'b0 && req_ready === 1'b1 && tok_valid === 1'b0, "idle in reset");
      reset = 1'b0;
      @(negedge clk);
      boot_pins = 8'h00;
      txn(1'b0, NCR_REG_DEVICE_ID, '0, 1'b1, 32'h005A_3C5E, 0);
      txn(1'b0, NCR_REG_SWITCH_CFG, '0, 1'b1, 32'h0, 0);
      txn(1'b1, NCR_REG_NODE_ID, 32'h0000_1234, 1'b1, '0, 1);
      check(node_id === 16'h1234, "node id after reset");
   endtask
   // Plain words reach their outputs without a tile reset; the JTAG ID copy refuses writes
   task automatic t_plain();
      txn(1'b1, NCR_REG_CLK_DIV, 32'h0000_0011, 1'b1, '0, 0);
      txn(1'b1, NCR_REG_REF_CLK, 32'h0000_0022, 1'b1, '0, 0);
      txn(1'b1, NCR_REG_DIR_LO, 32'h3300_0033, 1'b1, '0, 1);
      txn(1'b1, NCR_REG_DIR_HI, 32'h4400_0044, 1'b1, '0, 0);
      txn(1'b1, NCR_REG_DBG_T0, 32'h5500_0055, 1'b1, '0, 0);
      txn(1'b1, NCR_REG_DBG_T1, 32'h6600_0066, 1'b1, '0, 2);
      txn(1'b0, NCR_REG_DIR_HI, '0, 1'b1, 32'h4400_0044, 0);
      txn(1'b0, NCR_REG_DBG_T0, '0, 1'b1, 32'h5500_0055, 1);
      txn(1'b1, NCR_REG_JTAG_ID, 32'h0, 1'b0, '0, 0);
      txn(1'b0, NCR_REG_JTAG_ID, '0, 1'b1, 32'h1357_9BDF, 0);
      txn(1'b0, NCR_REG_USER_CODE, '0, 1'b1, 32'h2468_ACE0, 0);
      dbg_src = 32'h0F0F_F0F0;
      txn(1'b0, NCR_REG_DBG_SRC, '0, 1'b1, 32'h0F0F_F0F0, 0);
      check(clk_div === 32'h11 && ref_clk === 32'h22 && dir_lo === 32'h3300_0033, "outs a");
      check(dir_hi === 32'h4400_0044 && dbg_t0 === 32'h5500_0055, "outs b");
      check(dbg_t1 === 32'h6600_0066 && tr_seen === 1, "outs c");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence after a two-cycle reset
   initial begin
      reset = 1'b1;
      boot_pins = 8'hA5;
      dbg_src = 32'h1234_5678;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      t_reset_vals();
      t_node_id();
      t_refusals();
      t_pll();
      t_lock();
      t_again();
      t_plain();
      conclude();
   end
endmodule
`default_nettype wire
